// file: include/flash_pkg.sv
// shared constants, types and protection decode for the serial flash link
package flash_pkg;

  // --------------------------------------------------------------
  // operation codes
  // --------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;

  // --------------------------------------------------------------
  // status_and_protection fields
  // --------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_SIZE_LO = 2;
  localparam int ST_SIZE_HI = 4;
  localparam int ST_FROM_BOTTOM = 5;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_HOST_MASK = 8'h3F;

  // --------------------------------------------------------------
  // frame lengths in serial clock pulses, sector position
  // --------------------------------------------------------------
  localparam logic [15:0] BITS_OPCODE = 16'h0008;
  localparam logic [15:0] BITS_ONE_BYTE = 16'h0010;
  localparam logic [15:0] BITS_ADDR = 16'h0020;
  localparam logic [15:0] BITS_ADDR_DATA = 16'h0028;
  localparam int SECTOR_LSB = 16;

  // --------------------------------------------------------------
  // densities and array operation kinds
  // --------------------------------------------------------------
  localparam logic [2:0] DENS_8 = 3'h0;
  localparam logic [2:0] DENS_32 = 3'h1;
  localparam logic [2:0] DENS_64 = 3'h2;
  localparam logic [2:0] DENS_128 = 3'h3;
  localparam logic [1:0] OPK_PROGRAM = 2'h0;
  localparam logic [1:0] OPK_SECTOR = 2'h1;
  localparam logic [1:0] OPK_BULK = 2'h2;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLOCK_KHZ = 20000;
  localparam int WS_TIME_US = 10000;
  localparam int WS_MAX_US = 15000;
  localparam int WS_CYCLES = WS_TIME_US * CLOCK_KHZ / 1000;
  localparam logic [3:0] SCLK_HALF = 4'h4;
  localparam logic [3:0] FRAME_GAP = 4'h8;

  typedef enum logic [1:0] {H_IDLE, H_LOAD, H_SHIFT, H_GAP} host_state_e;

  // true when the sector lies in the shielded area for this density
  function automatic logic sector_protected(logic [2:0] dens, logic bottom,
                                            logic [2:0] size, logic [7:0] sector);
    logic [3:0] lg;
    logic [2:0] maxc;
    logic [2:0] extra;
    logic [8:0] n;
    logic [8:0] s;
    logic [8:0] cnt;
    lg = 4'h8;
    maxc = 3'h6;
    extra = 3'h2;
    case (dens)
      DENS_8: begin lg = 4'h3; maxc = 3'h3; extra = 3'h0; end
      DENS_32: begin lg = 4'h5; maxc = 3'h5; extra = 3'h0; end
      DENS_64: begin lg = 4'h6; maxc = 3'h6; extra = 3'h0; end
      DENS_128: begin lg = 4'h7; maxc = 3'h6; extra = 3'h1; end
      default: begin lg = 4'h8; maxc = 3'h6; extra = 3'h2; end
    endcase
    n = 9'h001 << lg;
    s = {1'b0, sector} & 9'(n - 9'h001);
    cnt = 9'h001 << 3'(size - 3'h1 + extra);
    if (size == 3'h0) return 1'b0;
    if (size > maxc) return 1'b1;
    return bottom ? (s < cnt) : (s >= 9'(n - cnt));
  endfunction

endpackage

// file: include/serial_flash_if.sv
// serial link between the flash device end and the host end
`timescale 1ns/1ps
interface serial_flash_if;
  logic chip_select_n;
  logic serial_clock;
  logic serial_in_line;
  logic serial_out_line;
  logic serial_out_oe;
  logic serial_out_seen;

  // line floats high when the device lets go
  assign serial_out_seen = serial_out_oe ? serial_out_line : 1'b1;

  modport device (input chip_select_n, input serial_clock, input serial_in_line,
                  output serial_out_line, output serial_out_oe);
  modport host (output chip_select_n, output serial_clock, output serial_in_line,
                input serial_out_seen);
endinterface

// file: logic/flash_device.sv
// device end: command capture, status register, protection and busy cycle
//
// Overview of operation
// R1: all bytes move most significant bit first
// R2: opcode captured on rising serial clock edges
// R3: read may end anywhere; stop driving
// R4: write/erase need whole bytes, else discarded
// R5: array access refused during busy cycle
// R6: status readable any time, repeatedly
// R7: host never writes ones to bits 7:6
// R8: bit 5 picks bottom or top start
// R9: bits 4:2 pick protected size
// R10: write latch gates program, status, erases
// R11: busy flag set during any cycle
// R12: bulk erase only unprotected; refuse protected
// R13: eight sector density decode
// R14: thirty-two sector density decode
// R15: sixty-four sector density decode
// R16: 128 sector density decode
// R17: 256 sector density decode
// R18: status write only touches protection bits
// R19: host sends write enable before status write
// R20: status write starts timed cycle
// R21: sector is address bits 23:16
// R22: addressed commands carry three address bytes
// R23: write enable sets the latch
// R24: latch cleared by reset, disable, completion
`timescale 1ns/1ps
module flash_device
  import flash_pkg::*;
#(
  parameter int WS_CYCLES_P = WS_CYCLES
) (
  // system side
  input wire logic clock,
  input wire logic reset,
  // link
  serial_flash_if.device link,
  // array side
  input wire logic [2:0] density_sel,
  input wire logic op_done,
  input wire logic [7:0] array_read_data,
  output logic op_start,
  output logic [1:0] op_kind,
  output logic [23:0] op_addr,
  output logic [7:0] op_data,
  output logic [7:0] status_word
);

  // ------------------------------------------------------------
  // link domain state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] bits;
    logic [31:0] shreg;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [23:0] addr;
    logic [7:0] byte4;
    logic [7:0] st_s1;
    logic [7:0] st_s2;
    logic [7:0] rd_s1;
    logic [7:0] rd_s2;
  } link_s;

  typedef struct packed {
    logic out_bit;
    logic out_oe;
  } drive_s;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [7:0] status;
    logic [17:0] timer;
    logic wr_cycle;
    logic start;
    logic [1:0] kind;
    logic [23:0] addr;
    logic [7:0] data;
  } core_s;

  link_s lk_q;
  link_s lk_d;
  logic fresh_q;
  drive_s dr_q;
  drive_s dr_d;
  core_s co_q;
  core_s co_d;

  // ------------------------------------------------------------
  // link domain: frame start marker, cleared by the first edge
  // ------------------------------------------------------------
  always_ff @(posedge link.serial_clock or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // input capture on rising edges, msb first
  always_comb begin
    lk_d = lk_q;
    lk_d.bits = fresh_q ? 16'h0001 : 16'(lk_q.bits + 16'h0001); // see R2
    lk_d.shreg = fresh_q ? {31'h0, link.serial_in_line}
                         : {lk_q.shreg[30:0], link.serial_in_line}; // see R1
    if (lk_d.bits == BITS_OPCODE) begin
      lk_d.opcode = lk_d.shreg[7:0]; // see R2
    end
    if (lk_d.bits == BITS_ONE_BYTE) begin
      lk_d.byte1 = lk_d.shreg[7:0];
    end
    if (lk_d.bits == BITS_ADDR) begin
      lk_d.addr = lk_d.shreg[23:0]; // see R22
    end
    if (lk_d.bits == BITS_ADDR_DATA) begin
      lk_d.byte4 = lk_d.shreg[7:0];
    end
    lk_d.st_s1 = co_q.status;
    lk_d.st_s2 = lk_q.st_s1;
    lk_d.rd_s1 = array_read_data;
    lk_d.rd_s2 = lk_q.rd_s1;
  end

  always_ff @(posedge link.serial_clock) begin
    lk_q <= lk_d;
  end

  // output on falling edges; released at once when select rises
  always_comb begin
    dr_d.out_bit = 1'b0;
    dr_d.out_oe = 1'b0;
    if (lk_q.bits >= BITS_OPCODE) begin
      case (lk_q.opcode)
        OP_READ_STATUS: begin
          dr_d.out_oe = 1'b1; // see R6
          dr_d.out_bit = lk_q.st_s2[3'(3'h7 - lk_q.bits[2:0])]; // see R1
        end
        OP_READ: begin
          if (lk_q.bits >= BITS_ADDR && !lk_q.st_s2[ST_BUSY]) begin // see R5
            dr_d.out_oe = 1'b1;
            dr_d.out_bit = lk_q.rd_s2[3'(3'h7 - lk_q.bits[2:0])];
          end
        end
        default: begin
          dr_d.out_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge link.serial_clock or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      dr_q <= '0; // see R3
    end else begin
      dr_q <= dr_d;
    end
  end

  assign link.serial_out_line = dr_q.out_bit;
  assign link.serial_out_oe = dr_q.out_oe;

  // ------------------------------------------------------------
  // system domain: end of frame decode and self-timed cycles
  // ------------------------------------------------------------
  logic cs_rise;
  logic busy;
  logic write_permit_latch;
  logic aligned;
  logic prot;
  assign cs_rise = co_q.cs_sync[1] & ~co_q.cs_sync[2];
  assign busy = co_q.status[ST_BUSY];
  assign write_permit_latch = co_q.status[ST_WEL];
  assign aligned = (lk_q.bits[2:0] == 3'h0);
  assign prot = sector_protected(density_sel, co_q.status[ST_FROM_BOTTOM],
                                 co_q.status[ST_SIZE_HI:ST_SIZE_LO],
                                 lk_q.addr[23:SECTOR_LSB]); // see R13 R14 R15 R16 R17 R21

  always_comb begin
    co_d = co_q;
    co_d.cs_sync = {co_q.cs_sync[1:0], link.chip_select_n};
    co_d.start = 1'b0;
    // self-timed status write
    if (co_q.wr_cycle) begin
      co_d.timer = 18'(co_q.timer + 18'h00001);
      if (co_q.timer == 18'(WS_CYCLES_P - 1)) begin
        co_d.wr_cycle = 1'b0;
        co_d.status[ST_BUSY] = 1'b0; // see R11 R20
        co_d.status[ST_WEL] = 1'b0; // see R24
      end
    end else if (busy && op_done) begin
      co_d.status[ST_BUSY] = 1'b0; // see R11
      co_d.status[ST_WEL] = 1'b0; // see R24
    end
    // held link words are stable: the link clock is idle after select rises
    if (cs_rise && !busy) begin // see R5
      case (lk_q.opcode)
        OP_WRITE_ENABLE: begin
          if (lk_q.bits == BITS_OPCODE) co_d.status[ST_WEL] = 1'b1; // see R23
        end
        OP_WRITE_DISABLE: begin
          if (lk_q.bits == BITS_OPCODE) co_d.status[ST_WEL] = 1'b0; // see R24
        end
        OP_WRITE_STATUS: begin
          if (lk_q.bits == BITS_ONE_BYTE && write_permit_latch) begin // see R4 R10
            co_d.status[ST_FROM_BOTTOM] = lk_q.byte1[ST_FROM_BOTTOM]; // see R8 R18
            co_d.status[ST_SIZE_HI:ST_SIZE_LO] = lk_q.byte1[ST_SIZE_HI:ST_SIZE_LO]; // see R9
            co_d.status[ST_BUSY] = 1'b1; // see R11 R20
            co_d.wr_cycle = 1'b1;
            co_d.timer = 18'h00000;
          end
        end
        OP_PROGRAM: begin
          if (lk_q.bits >= BITS_ADDR_DATA && aligned && write_permit_latch && !prot) begin // see R4 R12
            co_d.start = 1'b1;
            co_d.kind = OPK_PROGRAM;
            co_d.addr = lk_q.addr;
            co_d.data = lk_q.byte4;
            co_d.status[ST_BUSY] = 1'b1;
          end
        end
        OP_SECTOR_ERASE: begin
          if (lk_q.bits == BITS_ADDR && write_permit_latch && !prot) begin // see R4 R12
            co_d.start = 1'b1;
            co_d.kind = OPK_SECTOR;
            co_d.addr = lk_q.addr;
            co_d.status[ST_BUSY] = 1'b1;
          end
        end
        OP_BULK_ERASE: begin
          if (lk_q.bits == BITS_OPCODE && write_permit_latch
              && co_q.status[ST_SIZE_HI:ST_SIZE_LO] == 3'h0) begin // see R12
            co_d.start = 1'b1;
            co_d.kind = OPK_BULK;
            co_d.addr = 24'h000000;
            co_d.status[ST_BUSY] = 1'b1;
          end
        end
        default: begin
          co_d.start = 1'b0;
        end
      endcase
    end
    co_d.status[7:6] = 2'h0; // see R7
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      co_q <= '{cs_sync: 3'h7, status: STATUS_RESET, default: '0}; // see R24
    end else begin
      co_q <= co_d;
    end
  end

  // array side outputs
  assign op_start = co_q.start;
  assign op_kind = co_q.kind;
  assign op_addr = co_q.addr;
  assign op_data = co_q.data;
  assign status_word = co_q.status;

endmodule

// file: logic/flash_host.sv
// host end: frames commands, adds write enable, polls busy to completion
`timescale 1ns/1ps
module flash_host
  import flash_pkg::*;
(
  // system side
  input wire logic clock,
  input wire logic reset,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // link
  serial_flash_if.host link
);

  typedef struct packed {
    host_state_e state;
    logic [1:0] step;
    logic [3:0] ph;
    logic [5:0] cnt;
    logic [5:0] nbits;
    logic [39:0] tx;
    logic [7:0] rx;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic s1;
    logic s2;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] data;
    logic ready;
    logic rvalid;
  } host_s;

  localparam logic [1:0] STEP_WREN = 2'h0;
  localparam logic [1:0] STEP_MAIN = 2'h1;
  localparam logic [1:0] STEP_POLL = 2'h2;

  host_s q;
  host_s d;
  logic writes;
  assign writes = (q.op == OP_WRITE_STATUS) || (q.op == OP_PROGRAM)
                  || (q.op == OP_SECTOR_ERASE) || (q.op == OP_BULK_ERASE);

  // sequencer and serial clock divider
  always_comb begin
    d = q;
    d.s1 = link.serial_out_seen;
    d.s2 = q.s1;
    d.rvalid = 1'b0;
    case (q.state)
      H_IDLE: begin
        if (cmd_valid && q.ready) begin
          d.ready = 1'b0;
          d.op = cmd_op;
          d.addr = cmd_addr;
          d.data = cmd_data;
          d.step = STEP_WREN;
          if (!((cmd_op == OP_WRITE_STATUS) || (cmd_op == OP_PROGRAM)
                || (cmd_op == OP_SECTOR_ERASE) || (cmd_op == OP_BULK_ERASE))) begin
            d.step = STEP_MAIN;
          end
          d.state = H_LOAD;
        end
      end
      H_LOAD: begin
        d.tx = {OP_WRITE_ENABLE, 32'h0}; // see R19
        d.nbits = 6'd8;
        if (q.step == STEP_POLL) begin
          d.tx = {OP_READ_STATUS, 32'h0}; // see R20
          d.nbits = 6'd16;
        end else if (q.step == STEP_MAIN) begin
          case (q.op)
            OP_WRITE_STATUS: begin
              d.tx = {q.op, q.data & STATUS_HOST_MASK, 24'h0}; // see R7
              d.nbits = 6'd16;
            end
            OP_READ_STATUS: begin d.tx = {q.op, 32'h0}; d.nbits = 6'd16; end
            OP_READ: begin d.tx = {q.op, q.addr, 8'h00}; d.nbits = 6'd40; end // see R22
            OP_PROGRAM: begin d.tx = {q.op, q.addr, q.data}; d.nbits = 6'd40; end
            OP_SECTOR_ERASE: begin d.tx = {q.op, q.addr, 8'h00}; d.nbits = 6'd32; end
            default: begin d.tx = {q.op, 32'h0}; d.nbits = 6'd8; end
          endcase
        end
        d.cs_n = 1'b0;
        d.mosi = d.tx[39]; // see R1 R2
        d.ph = 4'h0;
        d.cnt = 6'd0;
        d.state = H_SHIFT;
      end
      H_SHIFT: begin
        d.ph = 4'(q.ph + 4'h1);
        if (q.ph == 4'(SCLK_HALF - 4'h1)) begin
          d.ph = 4'h0;
          if (!q.sclk) begin
            d.sclk = 1'b1;
            d.rx = {q.rx[6:0], q.s2}; // see R1
          end else begin
            d.sclk = 1'b0;
            d.cnt = 6'(q.cnt + 6'd1);
            d.tx = {q.tx[38:0], 1'b0};
            d.mosi = q.tx[38];
            if (d.cnt == q.nbits) begin
              d.cs_n = 1'b1; // see R4 R3
              d.state = H_GAP;
            end
          end
        end
      end
      H_GAP: begin
        d.ph = 4'(q.ph + 4'h1);
        if (q.ph == 4'(FRAME_GAP - 4'h1)) begin
          d.ph = 4'h0;
          d.state = H_LOAD;
          // write enable first, then the command, then poll until idle
          if (q.step == STEP_WREN) begin
            d.step = STEP_MAIN; // see R19
          end else if (q.step == STEP_MAIN && writes) begin
            d.step = STEP_POLL; // see R20
          end else if (!(q.step == STEP_POLL && q.rx[ST_BUSY])) begin
            d.state = H_IDLE;
            d.ready = 1'b1;
            d.rvalid = 1'b1;
          end
        end
      end
      default: begin
        d.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '{state: H_IDLE, cs_n: 1'b1, s1: 1'b1, s2: 1'b1, ready: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign link.chip_select_n = q.cs_n;
  assign link.serial_clock = q.sclk;
  assign link.serial_in_line = q.mosi;
  assign cmd_ready = q.ready;
  assign rsp_valid = q.rvalid;
  assign rsp_data = q.rx;

endmodule

// file: sim/serial_flash_checker.sv
// link protocol checker for the serial flash interface
`timescale 1ns/1ps
module serial_flash_checker (
  // system
  input wire logic clock,
  input wire logic reset,
  // link
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  input wire logic serial_out_seen
);
  logic sclk_q;
  logic [15:0] rises_q;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // count serial clock rises inside a frame
  always_ff @(posedge clock) begin
    sclk_q <= serial_clock;
    if (reset || chip_select_n) begin
      rises_q <= 16'h0000;
    end else if (serial_clock && !sclk_q) begin
      rises_q <= rises_q + 16'h0001;
    end
  end
  // ----------------------------------------
  // link assertions
  // ----------------------------------------
  property p_oe_off; chip_select_n |-> !serial_out_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
  property p_no_early_drive; !chip_select_n && rises_q < 16'h0008 |-> !serial_out_oe; endproperty
  a_no_early_drive: assert property (p_no_early_drive) else $error("drive during opcode");
  property p_whole_bytes;
    $rose(chip_select_n) |-> rises_q != 16'h0000 && rises_q[2:0] == 3'h0;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes) else $error("frame not whole bytes");
  property p_sclk_idle; chip_select_n |-> !serial_clock; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock runs outside frame");
  property p_high_phase; $rose(serial_clock) |-> serial_clock [*4] ##1 !serial_clock; endproperty
  a_high_phase: assert property (p_high_phase) else $error("high phase length wrong");
  property p_low_phase; $fell(serial_clock) |-> !serial_clock [*4]; endproperty
  a_low_phase: assert property (p_low_phase) else $error("low phase too short");
  property p_in_stable; serial_clock |-> $stable(serial_in_line); endproperty
  a_in_stable: assert property (p_in_stable) else $error("input moved while clock high");
  property p_out_on_fall;
    serial_out_oe && $past(serial_out_oe) && $changed(serial_out_line) |-> !serial_clock;
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved on rise");
  property p_gap; $rose(chip_select_n) |-> chip_select_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("frame gap too short");
  // main scenarios seen
  c_drive: cover property ($rose(serial_out_oe));
  c_zero_out: cover property (serial_out_oe && !serial_out_seen);
  c_long_frame: cover property ($rose(chip_select_n) && rises_q == 16'h0028);
endmodule

// file: sim/serial_flash_protect_status_tb.sv
// testbench joining host and device, plus a hand-driven link to a second device
`timescale 1ns/1ps
module serial_flash_protect_status_tb
  import flash_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_addr = 24'h000000;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, op_start, op_start_b;
  logic [7:0] rsp_data, op_data, status_word, status_b, data_seen;
  logic [2:0] density_sel = 3'h0;
  logic op_done = 1'b0;
  logic op_done_b = 1'b0;
  logic [7:0] array_read_data = 8'h00;
  logic [1:0] op_kind, kind_seen;
  logic [23:0] op_addr, addr_seen;
  int failures = 0;
  int comparisons = 0;
  int starts = 0;
  int starts_b = 0;
  int busy_cnt = 0;
  serial_flash_if link_a();
  serial_flash_if link_b();
  always #25 clock = ~clock;
  // ----------------------------------------
  // design ends and checker
  // ----------------------------------------
  flash_host flash_host_inst (.clock(clock), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(link_a));
  flash_device #(.WS_CYCLES_P(50)) flash_device_inst (.clock(clock), .reset(reset),
    .link(link_a), .density_sel(density_sel), .op_done(op_done),
    .array_read_data(array_read_data), .op_start(op_start), .op_kind(op_kind),
    .op_addr(op_addr), .op_data(op_data), .status_word(status_word));
  flash_device #(.WS_CYCLES_P(50)) flash_device_inst_b (.clock(clock), .reset(reset),
    .link(link_b), .density_sel(3'h1), .op_done(op_done_b), .array_read_data(8'h00),
    .op_start(op_start_b), .op_kind(), .op_addr(), .op_data(), .status_word(status_b));
  serial_flash_checker serial_flash_checker_inst (.clock(clock), .reset(reset),
    .chip_select_n(link_a.chip_select_n), .serial_clock(link_a.serial_clock),
    .serial_in_line(link_a.serial_in_line), .serial_out_line(link_a.serial_out_line),
    .serial_out_oe(link_a.serial_out_oe), .serial_out_seen(link_a.serial_out_seen));
  // array completion for the first device, busy and start counters
  always @(negedge clock) begin
    if (op_start === 1'b1) begin
      starts++;
      kind_seen = op_kind;
      addr_seen = op_addr;
      data_seen = op_data;
      repeat (20) @(negedge clock);
      op_done = 1'b1;
      @(negedge clock);
      op_done = 1'b0;
    end
  end
  always @(negedge clock) begin
    if (op_start_b === 1'b1) starts_b++;
    if (status_word[0] === 1'b1) busy_cnt++;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic host_cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
                          output logic [7:0] rsp);
    int n;
    @(negedge clock);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    @(negedge clock);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(posedge clock);
      #1 n++;
    end
    rsp = rsp_data;
    check("response arrived", 32'(n < 5000), 32'h1);
  endtask
  // bench-made link clock, 48 ns period, msb first
  task automatic frame_b(input logic [39:0] bits, input int n, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clock);
    #7 link_b.chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      link_b.serial_in_line = bits[39 - i];
      #24 rx = {rx[6:0], link_b.serial_out_seen};
      link_b.serial_clock = 1'b1;
      #24 link_b.serial_clock = 1'b0;
    end
    #24 link_b.chip_select_n = 1'b1;
    link_b.serial_in_line = ~link_b.serial_in_line;
    repeat (10) @(posedge clock);
  endtask
  function automatic int prot_cnt(input logic [2:0] d, input logic [2:0] sz, input int n);
    int base;
    int top;
    base = (d == 3'h3) ? 2 : (d > 3'h3) ? 4 : 1;
    top = (d == 3'h0) ? 3 : (d == 3'h1) ? 5 : 6;
    if (sz == 3'h0) return 0;
    if (int'(sz) > top) return n;
    return base << (sz - 3'h1);
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    logic [7:0] r;
    check("status after reset", status_word, STATUS_RESET);
    host_cmd(OP_READ_STATUS, 24'h000000, 8'h00, r);
    check("status read", r, 8'h00);
  endtask
  task automatic t_status_write;
    logic [7:0] r;
    busy_cnt = 0;
    host_cmd(OP_WRITE_STATUS, 24'h000000, 8'hFC, r);
    check("status reply", r, 8'h3C);
    check("status register", status_word, 8'h3C);
    check("busy span", 32'(busy_cnt >= 50 && busy_cnt <= 52), 32'h1);
  endtask
  task automatic t_protect;
    logic [6:0] cases [12] = '{7'h03, 7'h09, 7'h04, 7'h1D, 7'h16, 7'h26, 7'h2F, 7'h39,
                               7'h36, 7'h41, 7'h4E, 7'h40};
    logic [7:0] r, sec, op;
    int n, c, a, s0;
    logic exp;
    for (int k = 0; k < 12; k++) begin
      @(negedge clock);
      density_sel = cases[k][6:4];
      host_cmd(OP_WRITE_STATUS, 24'h000000, {2'h0, cases[k][3:0], 2'h0}, r);
      n = (cases[k][6:4] > 3'h3) ? 256 : (cases[k][6:4] == 3'h0) ? 8 : 16 << cases[k][6:4];
      c = prot_cnt(cases[k][6:4], cases[k][2:0], n);
      a = cases[k][3] ? c : n - c;
      for (int j = 0; j < 2; j++) begin
        sec = 8'((a + n - j) % n);
        op = j ? OP_SECTOR_ERASE : OP_PROGRAM;
        exp = cases[k][3] ? (int'(sec) >= c) : (int'(sec) < n - c);
        s0 = starts;
        host_cmd(op, {sec, 16'h0000}, 8'h5A, r);
        check("array start", 32'(starts - s0), 32'(exp));
        if (exp) begin
          check("op kind", kind_seen, j ? OPK_SECTOR : OPK_PROGRAM);
          check("op address", addr_seen, {sec, 16'h0000});
        end
      end
    end
    check("program data", data_seen, 8'h5A);
  endtask
  task automatic t_bulk;
    logic [7:0] r;
    int s0;
    host_cmd(OP_WRITE_STATUS, 24'h000000, 8'h04, r);
    s0 = starts;
    host_cmd(OP_BULK_ERASE, 24'h000000, 8'h00, r);
    check("bulk refused", 32'(starts - s0), 32'h0);
    host_cmd(OP_WRITE_STATUS, 24'h000000, 8'h20, r);
    host_cmd(OP_BULK_ERASE, 24'h000000, 8'h00, r);
    check("bulk run", 32'(starts - s0), 32'h1);
    check("bulk kind", kind_seen, OPK_BULK);
    check("latch cleared", status_word, 8'h20);
  endtask
  task automatic t_read;
    logic [7:0] r;
    @(negedge clock);
    array_read_data = 8'hB4;
    host_cmd(OP_READ, 24'h123456, 8'h00, r);
    check("read byte", r, 8'hB4);
  endtask
  task automatic t_link_b;
    logic [7:0] rx;
    frame_b({OP_PROGRAM, 24'h010000, 8'h11}, 40, rx);
    check("program without latch", 32'(starts_b), 32'h0);
    frame_b({OP_WRITE_ENABLE, 32'h0}, 8, rx);
    check("latch set", status_b, 8'h02);
    frame_b({OP_WRITE_DISABLE, 32'h0}, 8, rx);
    check("latch off", status_b, 8'h00);
    frame_b({OP_WRITE_ENABLE, 32'h0}, 8, rx);
    frame_b({OP_WRITE_STATUS, 8'h1C, 24'h0}, 15, rx);
    check("short frame dropped", status_b, 8'h02);
    frame_b({OP_PROGRAM, 24'h020000, 8'h77}, 40, rx);
    check("program start", 32'(starts_b), 32'h1);
    check("busy shown", status_b, 8'h03);
    frame_b({OP_READ, 32'h0}, 40, rx);
    check("read while busy", rx, 8'hFF);
    frame_b({OP_READ_STATUS, 32'h0}, 24, rx);
    check("status twice", rx, 8'h03);
    @(negedge clock);
    op_done_b = 1'b1;
    @(negedge clock);
    op_done_b = 1'b0;
    repeat (4) @(posedge clock);
    check("cycle end", status_b, 8'h00);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    // late enough that the device sees a select edge and marks a fresh frame
    #1;
    link_b.chip_select_n = 1'b1;
    link_b.serial_clock = 1'b0;
    link_b.serial_in_line = 1'b0;
    repeat (16) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    t_reset_values();
    t_status_write();
    t_protect();
    t_bulk();
    t_read();
    t_link_b();
    tally_and_finish();
  end
  initial begin
    #4000000;
    failures++;
    tally_and_finish();
  end
endmodule
